// ==== logic/pid_arb.sv ====
`timescale 1ns/1ns
// fixed priority pick: a, b, c, periodic, d
module pid_arb (
	input wire logic [4:0] pend,
	output logic any,
	output logic [2:0] idx,
	output logic [4:0] onehot
);
	// priority index of highest pending source
	function automatic logic [2:0] pick(input logic [4:0] p);
		logic [2:0] r;
		r = 3'h0;
		if (p[0]) begin
			r = 3'h0;
		end else if (p[1]) begin
			r = 3'h1;
		end else if (p[2]) begin
			r = 3'h2;
		end else if (p[4]) begin
			r = 3'h4;
		end else begin
			r = 3'h3;
		end
		return r;
	endfunction

	always_comb begin
		any = |pend;
		idx = pick(pend);
		onehot = any ? (5'h01 << idx) : 5'h00;
	end
endmodule

// ==== logic/pid_pkg.sv ====
package pid_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LATENCY_NS = 60000;
	localparam int LATENCY_CYC = (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RUN_LIMIT_US = 670;
	localparam int RUN_LIMIT_CYC = (RUN_LIMIT_US * 1000) / CLK_PERIOD_NS;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	// sources and limits
	localparam int NSRC = 5;
	localparam logic [2:0] SRC_PERIODIC = 3'h4;
	localparam logic [1:0] NEST_MAX = 2'h3;
	localparam logic [7:0] IVL_MIN_MS = 8'h0A;
	localparam logic [7:0] IVL_MAX_MS = 8'h8C;
	localparam logic [7:0] IVL_RST = 8'h0A;
	localparam logic [4:0] ENABLE_RST = 5'h1F;
	localparam int LABEL_W = 16;
	localparam int ADDR_W = 16;
	// register byte offsets
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_UNMASK = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_INTERVAL = 8'h0C;
	localparam logic [7:0] OFS_VEC0 = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_STS = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
	// status and event bit positions
	localparam int ST_ERR = 0;
	localparam int ST_BUSY = 1;
	localparam int EV_DISPATCH = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_RESUME = 2;
	localparam int NEV = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_DISPATCH, ST_RUN} pid_state_type;
	typedef struct packed {
		logic valid;
		logic [LABEL_W-1:0] label;
	} pid_jump_type;
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
	} pid_resume_type;
	typedef struct packed {
		logic handler_return_op;
		logic sub_call;
		logic sub_return;
	} pid_core_op_type;
endpackage

// ==== logic/pid_tick.sv ====
`timescale 1ns/1ns
// periodic tick generator, interval in milliseconds
module pid_tick #(
	parameter int CYC_PER_MS = pid_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic en,
	input wire logic [7:0] interval_ms,
	output logic tick
);
	logic [15:0] cyc_ff; // cycles within one ms
	logic [7:0] ms_ff; // ms within one interval
	logic tick_ff; // one-cycle tick
	localparam logic [15:0] CYC_LAST = 16'(CYC_PER_MS - 1);

	// counters restart while disabled
	always_ff @(posedge clk) begin
		tick_ff <= 1'b0;
		if (reset || !en) begin
			cyc_ff <= 16'h0000;
			ms_ff <= 8'h00;
		end else if (cyc_ff == CYC_LAST) begin
			cyc_ff <= 16'h0000;
			if (ms_ff >= interval_ms - 8'h01) begin
				ms_ff <= 8'h00;
				tick_ff <= 1'b1;
			end else begin
				ms_ff <= ms_ff + 8'h01;
			end
		end else begin
			cyc_ff <= cyc_ff + 16'h0001;
		end
	end
	assign tick = tick_ff;
endmodule

// ==== logic/pid_top.sv ====
`timescale 1ns/1ns
//
// Overview of operation
// - periodic tick enters its vector slot handler
// - handler return resumes at interrupted address
// - fourth nested call raises execution error
// - five vector slots: a,b,c,d,periodic
// - grant order a,b,c,periodic,d
// - one handler at a time only
// - periodic handler over 670 us errors
// - dispatch latency about 60 us
// - periodic interval 10 to 140 ms
// - per-source enables, periodic enabled flag
//
module pid_top #(
	parameter int CYC_PER_MS = pid_pkg::CYC_PER_MS,
	parameter int RUN_LIMIT_CYC = pid_pkg::RUN_LIMIT_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_irq_a,
	input wire logic ext_irq_b,
	input wire logic ext_irq_c,
	input wire logic ext_irq_d,
	input wire logic [15:0] pc_in,
	input wire pid_pkg::pid_core_op_type core_op,
	output pid_pkg::pid_jump_type jump,
	output pid_pkg::pid_resume_type resume,
	output logic exec_error_flag,
	output logic err_led,
	output logic periodic_enabled_flag,
	output logic irq
);
	localparam logic [15:0] LAT_LAST = 16'(pid_pkg::LATENCY_CYC - 1);
	localparam logic [15:0] RUN_LAST = 16'(RUN_LIMIT_CYC - 1);

	// bus state
	logic wait_ff; // waitrequest flop
	logic [31:0] rdata_ff; // read data flop
	logic wr_acc; // write takes effect this edge
	logic [31:0] rd_mux; // read data source
	// configuration
	logic [4:0] enable_ff; // per-source enables
	logic [7:0] interval_ff; // periodic interval in ms
	logic [15:0] vec_ff [pid_pkg::NSRC]; // handler labels
	logic [pid_pkg::NEV-1:0] irq_sts_ff; // sticky events
	logic [pid_pkg::NEV-1:0] irq_mask_ff; // event mask
	logic [pid_pkg::NEV-1:0] nxt_irq_sts;
	logic irq_ff;
	// request path
	logic [3:0] ext_prev_ff; // previous input levels
	logic [4:0] raw_req; // new requests this cycle
	logic [4:0] pend_ff; // latched requests
	logic tick; // periodic tick
	logic arb_any;
	logic [2:0] arb_idx;
	logic [4:0] arb_oh;
	logic [4:0] grant_oh; // granted source this cycle
	logic grant_fire;
	// dispatch
	pid_pkg::pid_state_type state_ff;
	logic [2:0] src_ff; // active source
	logic [15:0] disp_cnt_ff; // latency counter
	logic [15:0] run_cnt_ff; // handler run time
	logic [1:0] depth_ff; // nested call depth
	logic [15:0] resume_addr_ff; // interrupted address
	pid_pkg::pid_jump_type jump_ff;
	pid_pkg::pid_resume_type resume_ff;
	logic err_ff;
	logic led_ff;
	logic set_err_nest;
	logic set_err_run;
	logic clr_err;
	logic nxt_err;
	logic in_run;
	logic ret_now;

	// map byte address to vector slot
	function automatic logic is_slot(input logic [7:0] a);
		return (a >= pid_pkg::OFS_VEC0) && (a < pid_pkg::OFS_VEC0 + 8'h14) && (a[1:0] == 2'h0);
	endfunction
	function automatic logic [2:0] slot_of(input logic [7:0] a);
		logic [7:0] d;
		d = a - pid_pkg::OFS_VEC0;
		return d[4:2];
	endfunction

	// waitrequest: one wait cycle then accept
	always_ff @(posedge clk) begin
		if (reset) begin
			wait_ff <= 1'b1;
		end else if ((avs_read || avs_write) && wait_ff) begin
			wait_ff <= 1'b0;
		end else begin
			wait_ff <= 1'b1;
		end
	end
	assign wr_acc = avs_write && !wait_ff;

	// read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_slot(avs_address)) begin
			rd_mux[15:0] = vec_ff[slot_of(avs_address)];
		end else begin
			case (avs_address)
				pid_pkg::OFS_ENABLE: rd_mux[4:0] = enable_ff;
				pid_pkg::OFS_INTERVAL: rd_mux[7:0] = interval_ff;
				pid_pkg::OFS_STATUS: begin
					rd_mux[pid_pkg::ST_ERR] = err_ff;
					rd_mux[pid_pkg::ST_BUSY] = (state_ff != pid_pkg::ST_IDLE);
					rd_mux[3:2] = depth_ff;
					rd_mux[6:4] = src_ff;
					rd_mux[12:8] = pend_ff;
				end
				pid_pkg::OFS_IRQ_STS: rd_mux[pid_pkg::NEV-1:0] = irq_sts_ff;
				pid_pkg::OFS_IRQ_MASK: rd_mux[pid_pkg::NEV-1:0] = irq_mask_ff;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data captured in the wait cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read && wait_ff) begin
			rdata_ff <= rd_mux;
		end
	end

	// source enables, unmask and mask operations
	always_ff @(posedge clk) begin
		if (reset) begin
			enable_ff <= pid_pkg::ENABLE_RST;
		end else if (wr_acc && avs_address == pid_pkg::OFS_UNMASK) begin
			enable_ff <= enable_ff | avs_writedata[4:0];
		end else if (wr_acc && avs_address == pid_pkg::OFS_MASK) begin
			enable_ff <= enable_ff & ~avs_writedata[4:0];
		end else if (wr_acc && avs_address == pid_pkg::OFS_ENABLE) begin
			enable_ff <= avs_writedata[4:0];
		end
	end

	// interval, clamped to legal range
	always_ff @(posedge clk) begin
		if (reset) begin
			interval_ff <= pid_pkg::IVL_RST;
		end else if (wr_acc && avs_address == pid_pkg::OFS_INTERVAL) begin
			if (avs_writedata[31:8] != 24'h000000 || avs_writedata[7:0] > pid_pkg::IVL_MAX_MS) begin
				interval_ff <= pid_pkg::IVL_MAX_MS;
			end else if (avs_writedata[7:0] < pid_pkg::IVL_MIN_MS) begin
				interval_ff <= pid_pkg::IVL_MIN_MS;
			end else begin
				interval_ff <= avs_writedata[7:0];
			end
		end
	end

	// vector slots
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < pid_pkg::NSRC; i++) begin
				vec_ff[i] <= 16'h0000;
			end
		end else if (wr_acc && is_slot(avs_address)) begin
			vec_ff[slot_of(avs_address)] <= avs_writedata[15:0];
		end
	end

	// periodic tick source
	pid_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
		.clk(clk),
		.reset(reset),
		.en(enable_ff[pid_pkg::SRC_PERIODIC]),
		.interval_ms(interval_ff),
		.tick(tick)
	);

	// rising edges of external inputs
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_prev_ff <= 4'h0;
		end else begin
			ext_prev_ff <= {ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a};
		end
	end
	assign raw_req = {tick, {ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a} & ~ext_prev_ff};

	// pending latch; a new request beats the grant clear
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_ff <= 5'h00;
		end else begin
			pend_ff <= (pend_ff & ~grant_oh) | (raw_req & enable_ff);
		end
	end

	pid_arb u_arb (
		.pend(pend_ff),
		.any(arb_any),
		.idx(arb_idx),
		.onehot(arb_oh)
	);
	assign grant_fire = arb_any && (state_ff == pid_pkg::ST_IDLE);
	assign grant_oh = grant_fire ? arb_oh : 5'h00;
	assign in_run = (state_ff == pid_pkg::ST_RUN);
	assign ret_now = in_run && core_op.handler_return_op;

	// dispatch sequence
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= pid_pkg::ST_IDLE;
			src_ff <= 3'h0;
			disp_cnt_ff <= 16'h0000;
			resume_addr_ff <= 16'h0000;
			jump_ff <= '0;
			resume_ff <= '0;
		end else begin
			jump_ff.valid <= 1'b0;
			resume_ff.valid <= 1'b0;
			case (state_ff)
				pid_pkg::ST_IDLE: begin
					if (grant_fire) begin
						src_ff <= arb_idx;
						resume_addr_ff <= pc_in;
						disp_cnt_ff <= 16'h0000;
						state_ff <= pid_pkg::ST_DISPATCH;
					end
				end
				pid_pkg::ST_DISPATCH: begin
					if (disp_cnt_ff == LAT_LAST) begin
						jump_ff.valid <= 1'b1;
						jump_ff.label <= vec_ff[src_ff];
						state_ff <= pid_pkg::ST_RUN;
					end else begin
						disp_cnt_ff <= disp_cnt_ff + 16'h0001;
					end
				end
				pid_pkg::ST_RUN: begin
					if (core_op.handler_return_op) begin
						resume_ff.valid <= 1'b1;
						resume_ff.addr <= resume_addr_ff;
						state_ff <= pid_pkg::ST_IDLE;
					end
				end
				default: state_ff <= pid_pkg::ST_IDLE;
			endcase
		end
	end

	// nested call depth inside a handler
	always_ff @(posedge clk) begin
		if (reset || !in_run) begin
			depth_ff <= 2'h0;
		end else if (core_op.sub_call && depth_ff != pid_pkg::NEST_MAX) begin
			depth_ff <= depth_ff + 2'h1;
		end else if (core_op.sub_return && depth_ff != 2'h0) begin
			depth_ff <= depth_ff - 2'h1;
		end
	end
	assign set_err_nest = in_run && core_op.sub_call && depth_ff == pid_pkg::NEST_MAX;

	// handler run time, saturating
	always_ff @(posedge clk) begin
		if (reset || !in_run) begin
			run_cnt_ff <= 16'h0000;
		end else if (run_cnt_ff != 16'hFFFF) begin
			run_cnt_ff <= run_cnt_ff + 16'h0001;
		end
	end
	assign set_err_run = in_run && src_ff == pid_pkg::SRC_PERIODIC && run_cnt_ff == RUN_LAST;

	// error flag: set wins over write-one clear
	assign clr_err = wr_acc && avs_address == pid_pkg::OFS_STATUS && avs_writedata[pid_pkg::ST_ERR];
	assign nxt_err = (err_ff && !clr_err) || set_err_nest || set_err_run;
	always_ff @(posedge clk) begin
		if (reset) begin
			err_ff <= 1'b0;
			led_ff <= 1'b0;
		end else begin
			err_ff <= nxt_err;
			led_ff <= nxt_err;
		end
	end

	// sticky events, mask, interrupt line
	always_comb begin
		nxt_irq_sts = irq_sts_ff;
		if (wr_acc && avs_address == pid_pkg::OFS_IRQ_STS) begin
			nxt_irq_sts = nxt_irq_sts & ~avs_writedata[pid_pkg::NEV-1:0];
		end
		nxt_irq_sts[pid_pkg::EV_DISPATCH] = nxt_irq_sts[pid_pkg::EV_DISPATCH] | grant_fire;
		nxt_irq_sts[pid_pkg::EV_ERROR] = nxt_irq_sts[pid_pkg::EV_ERROR] | set_err_nest | set_err_run;
		nxt_irq_sts[pid_pkg::EV_RESUME] = nxt_irq_sts[pid_pkg::EV_RESUME] | ret_now;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_sts_ff <= '0;
			irq_mask_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			irq_sts_ff <= nxt_irq_sts;
			irq_ff <= |(nxt_irq_sts & irq_mask_ff);
			if (wr_acc && avs_address == pid_pkg::OFS_IRQ_MASK) begin
				irq_mask_ff <= avs_writedata[pid_pkg::NEV-1:0];
			end
		end
	end

	// outputs straight from flops
	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign jump = jump_ff;
	assign resume = resume_ff;
	assign exec_error_flag = err_ff;
	assign err_led = led_ff;
	assign periodic_enabled_flag = enable_ff[pid_pkg::SRC_PERIODIC];
	assign irq = irq_ff;

	// cycles since last grant, for latency check
	logic [15:0] since_grant_ff;
	always_ff @(posedge clk) begin
		if (reset || grant_fire) begin
			since_grant_ff <= 16'h0000;
		end else if (since_grant_ff != 16'hFFFF) begin
			since_grant_ff <= since_grant_ff + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_nest_err;
		in_run && core_op.sub_call && depth_ff == 2'h3 |=> err_ff && led_ff;
	endproperty
	a_nest_err: assert property (p_nest_err) else $error("fourth nested call did not raise error");
	property p_resume_addr;
		ret_now |=> resume.valid && resume.addr == $past(resume_addr_ff);
	endproperty
	a_resume_addr: assert property (p_resume_addr) else $error("resume address wrong");
	property p_single;
		grant_fire |-> state_ff == pid_pkg::ST_IDLE ##1 state_ff == pid_pkg::ST_DISPATCH;
	endproperty
	a_single: assert property (p_single) else $error("grant while a handler is active");
	property p_latency;
		$rose(jump.valid) |-> since_grant_ff == 16'(pid_pkg::LATENCY_CYC);
	endproperty
	a_latency: assert property (p_latency) else $error("dispatch latency wrong");
	property p_vector;
		jump.valid |-> jump.label == vec_ff[src_ff];
	endproperty
	a_vector: assert property (p_vector) else $error("jump label not from slot");
	property p_prio;
		grant_fire |-> (pend_ff[0] ? arb_idx == 3'h0 : 1'b1) && (pend_ff[3] && !pend_ff[4] && pend_ff[2:0] == 3'h0
			? arb_idx == 3'h3 : arb_idx != 3'h3);
	endproperty
	a_prio: assert property (p_prio) else $error("wrong grant order");
	property p_overrun;
		in_run && src_ff == 3'h4 && run_cnt_ff == RUN_LAST |=> err_ff;
	endproperty
	a_overrun: assert property (p_overrun) else $error("periodic overrun not flagged");
	property p_hold;
		1'b1 |=> ($past(pend_ff) & ~$past(grant_oh) & ~pend_ff) == 5'h00;
	endproperty
	a_hold: assert property (p_hold) else $error("pending request lost");
	property p_sticky;
		err_ff && !clr_err |=> err_ff && led_ff;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag dropped");
	property p_tick;
		tick && enable_ff[4] |=> pend_ff[4] || state_ff == pid_pkg::ST_DISPATCH;
	endproperty
	a_tick: assert property (p_tick) else $error("periodic tick not latched");

	c_periodic: cover property (grant_fire && arb_idx == 3'h4);
	c_nest: cover property (set_err_nest);
	c_resume: cover property (resume.valid);
	c_overrun: cover property (set_err_run);
endmodule

// ==== verif/pid_top_bench.sv ====
`timescale 1ns/1ns
// one compare: counts it, reports a mismatch at once
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pid_top_bench;
	logic clk; // 10 MHz core clock
	logic reset; // synchronous, active high
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d;
	logic [15:0] pc_in; // main program address seen by the dispatcher
	pid_pkg::pid_core_op_type core_op;
	pid_pkg::pid_jump_type jump;
	pid_pkg::pid_resume_type resume;
	logic exec_error_flag, err_led, periodic_enabled_flag, irq;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0; // timeout counter
	int last_lat; // cycles spent in the last jump wait
	logic [31:0] seed = 32'h9373; // xorshift state
	logic [15:0] vec [5]; // model of the slots: a, b, c, d, periodic
	int order_q[$]; // model of the grant order
	logic [15:0] exp_pc; // address the next resume must carry
	logic in_h = 1'b0; // model: a handler is running
	logic [31:0] rd;
	// short counts: 1 ms = 10 cycles, run limit 50 cycles
	pid_top #(.CYC_PER_MS(10), .RUN_LIMIT_CYC(50)) dut (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .ext_irq_c(ext_irq_c),
		.ext_irq_d(ext_irq_d), .pc_in(pc_in), .core_op(core_op), .jump(jump), .resume(resume),
		.exec_error_flag(exec_error_flag), .err_led(err_led), .periodic_enabled_flag(periodic_enabled_flag),
		.irq(irq));
	// clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// pseudo random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// verdict and end of run
	task final_report;
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		// no own limit: only the hang guard ends this wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	// one cycle core operation pulse
	task automatic pulse(input logic [2:0] op);
		core_op <= op;
		@(posedge clk);
		core_op <= 3'h0;
		@(posedge clk);
	endtask
	// bounded wait for a handler entry
	task automatic wait_jump;
		last_lat = 0;
		do begin
			@(posedge clk);
			last_lat++;
		end while (jump.valid !== 1'b1 && last_lat < 2000);
		if (last_lat >= 2000) n_errors++;
	endtask
	// return op for one cycle, then bounded wait for the one-cycle resume pulse
	task automatic wait_resume;
		int n;
		n = 0;
		core_op <= 3'h4;
		@(posedge clk);
		core_op <= 3'h0;
		do begin
			@(posedge clk);
			n++;
		end while (resume.valid !== 1'b1 && n < 50);
		`CHK(resume.valid, 1'b1)
		`CHK(resume.addr, exp_pc)
	endtask
	// serve one handler: check label, optionally stay long or mask periodic, return
	// handler work starts only after entry, lasts hold cycles, issues no call, only the return op
	task automatic serve(input int src, input bit mask_p, input int hold);
		logic [15:0] nxt;
		wait_jump();
		`CHK(jump.label, vec[src])
		if (src == 0) begin
			`CHK(last_lat + 3 >= 598 && last_lat + 3 <= 608, 1'b1)
			bus(1'b0, pid_pkg::OFS_STATUS, 32'h0, rd);
			`CHK(rd[12:8], 5'h0E)
			`CHK(rd[1], 1'b1)
		end
		repeat (hold) @(posedge clk);
		if (mask_p) bus(1'b1, pid_pkg::OFS_MASK, 32'h10, rd);
		seed = xs(seed);
		nxt = seed[15:0];
		pc_in <= nxt;
		wait_resume();
		exp_pc = nxt;
	endtask
	// second handler entry before a return means two handlers at once
	always @(posedge clk) begin
		if (!reset && jump.valid === 1'b1) begin
			`CHK(in_h, 1'b0)
			in_h = 1'b1;
		end
		if (resume.valid === 1'b1) in_h = 1'b0;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 15000) begin
			n_errors++;
			final_report();
		end
	end
	// main sequence; no data link is modelled, so no link rate is chosen
	initial begin
		reset = 1'b1;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		{ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d} = 4'h0;
		pc_in = 16'h0000;
		core_op = 3'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK(periodic_enabled_flag, 1'b1)
		`CHK({exec_error_flag, err_led, irq}, 3'h0)
		bus(1'b1, pid_pkg::OFS_MASK, 32'h10, rd);
		`CHK(periodic_enabled_flag, 1'b0)
		bus(1'b0, pid_pkg::OFS_ENABLE, 32'h0, rd);
		`CHK(rd, 32'h0000000F)
		// interval clamping: low, high, then an unmapped read
		foreach (order_q[i]) order_q.delete();
		bus(1'b1, pid_pkg::OFS_INTERVAL, 32'h05, rd);
		bus(1'b0, pid_pkg::OFS_INTERVAL, 32'h0, rd);
		`CHK(rd, 32'h0000000A)
		bus(1'b1, pid_pkg::OFS_INTERVAL, 32'hFF, rd);
		bus(1'b0, pid_pkg::OFS_INTERVAL, 32'h0, rd);
		`CHK(rd, 32'h0000008C)
		bus(1'b0, 8'h30, 32'h0, rd);
		`CHK(rd, 32'h00000000)
		// vector slots with random labels
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			vec[i] = seed[15:0];
			bus(1'b1, 8'(int'(pid_pkg::OFS_VEC0) + 4 * i), {16'h0000, vec[i]}, rd);
			bus(1'b0, 8'(int'(pid_pkg::OFS_VEC0) + 4 * i), 32'h0, rd);
			`CHK(rd, {16'h0000, vec[i]})
		end
		// a disabled source is not latched
		bus(1'b1, pid_pkg::OFS_MASK, 32'h02, rd);
		ext_irq_b <= 1'b1;
		repeat (3) @(posedge clk);
		ext_irq_b <= 1'b0;
		bus(1'b0, pid_pkg::OFS_STATUS, 32'h0, rd);
		`CHK(rd[12:8], 5'h00)
		bus(1'b1, pid_pkg::OFS_UNMASK, 32'h12, rd);
		// four inputs at once, periodic tick lands during the third handler
		seed = xs(seed);
		exp_pc = seed[15:0];
		pc_in <= exp_pc;
		{ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d} <= 4'hF;
		repeat (3) @(posedge clk);
		{ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d} <= 4'h0;
		order_q = {0, 1, 2, 4, 3};
		foreach (order_q[i]) serve(order_q[i], order_q[i] == 4, 0);
		`CHK(exec_error_flag, 1'b0)
		// nesting: three calls allowed, the fourth flags an error
		bus(1'b1, pid_pkg::OFS_IRQ_MASK, 32'h0, rd);
		ext_irq_a <= 1'b1;
		@(posedge clk);
		ext_irq_a <= 1'b0;
		wait_jump();
		repeat (3) pulse(3'h2);
		@(posedge clk);
		`CHK(exec_error_flag, 1'b0)
		pulse(3'h2);
		@(posedge clk);
		`CHK({exec_error_flag, err_led}, 2'h3)
		`CHK(irq, 1'b0)
		bus(1'b1, pid_pkg::OFS_IRQ_MASK, 32'h2, rd);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		bus(1'b0, pid_pkg::OFS_IRQ_STS, 32'h0, rd);
		`CHK(rd[1], 1'b1)
		bus(1'b1, pid_pkg::OFS_IRQ_STS, 32'h7, rd);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		repeat (3) pulse(3'h1);
		wait_resume();
		`CHK({exec_error_flag, err_led}, 2'h3)
		bus(1'b1, pid_pkg::OFS_STATUS, 32'h1, rd);
		@(posedge clk);
		`CHK({exec_error_flag, err_led}, 2'h0)
		// periodic every 100 cycles: a short handler, then one that overruns
		bus(1'b1, pid_pkg::OFS_INTERVAL, 32'h0A, rd);
		bus(1'b1, pid_pkg::OFS_UNMASK, 32'h10, rd);
		serve(4, 1'b0, 0);
		`CHK(exec_error_flag, 1'b0)
		serve(4, 1'b1, 60);
		`CHK({exec_error_flag, err_led}, 2'h3)
		final_report();
	end
endmodule
